// ### rxap_pkg.sv
package rxap_pkg;

  localparam int unsigned CFG_W         = 20;
  localparam logic [19:0] CFG_RESET     = 20'h42e78;
  localparam int unsigned BIT_AP_EN     = 15;
  localparam int unsigned BIT_SQ        = 17;
  localparam int unsigned SLP_LSB       = 12;
  localparam int unsigned WIN_LSB       = 9;
  localparam int unsigned VCNT_LSB      = 7;
  localparam int unsigned SLICE_LSB     = 5;
  localparam int unsigned BW_LSB        = 3;

  localparam int unsigned CLK_MHZ       = 25;
  localparam int unsigned SLEEP_BASE_MS = 10;
  localparam int unsigned SLEEP_BASE_CYC = SLEEP_BASE_MS * CLK_MHZ * 1000;
  localparam int unsigned SER_MIN_KHZ   = 5;
  localparam int unsigned SER_TMO_CYC   = CLK_MHZ * 1000 / SER_MIN_KHZ;
  localparam int unsigned HOST_HALF_NS  = 1000;
  localparam int unsigned HOST_HALF_CYC = HOST_HALF_NS * CLK_MHZ / 1000;
  localparam int unsigned BAD_LIMIT     = 4;

  // bit-check window in us at 433.92 MHz, index {bandwidth, window code}
  localparam int unsigned WIN_US_TBL [0:31] = '{
    570, 532, 494, 457, 419, 381, 343, 305,
    285, 266, 247, 228, 209, 190, 172, 152,
    143, 133, 124, 114, 105,  95,  86,  76,
     71,  67,  62,  57,  52,  48,  43,  38};

  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_PINS   = 4'h8;
  localparam int unsigned CMD_FIRST_LSB = 20;
  localparam logic [2:0] PINS_RESET = 3'h7;

  typedef enum logic [3:0] {
    RXAP_AWAKE = 4'h1,
    RXAP_SLEEP = 4'h2,
    RXAP_POLL  = 4'h4,
    RXAP_RECV  = 4'h8
  } rxap_ap_t;

  function automatic logic [4:0] rxap_valid_need(input logic [1:0] code);
    unique case (code)
      2'h0: rxap_valid_need = 5'h00;
      2'h1: rxap_valid_need = 5'h04;
      2'h2: rxap_valid_need = 5'h08;
      2'h3: rxap_valid_need = 5'h10;
    endcase
  endfunction

endpackage

// ### rxap_if.sv
`timescale 1ns/1ps
interface rxap_if;
  logic sclk;
  logic dev_do_o;
  logic dev_do_oe;
  logic host_do_o;
  logic host_do_oe;
  logic do_line;
  logic squelch_select_pin;
  logic parallel_bw_select_0;
  logic parallel_bw_select_1;

  // weak pull-down when nobody drives
  assign do_line = dev_do_oe ? dev_do_o : (host_do_oe ? host_do_o : 1'b0);

  modport dev (
    input  sclk,
    input  do_line,
    input  squelch_select_pin,
    output dev_do_o,
    output dev_do_oe
  );

  modport host (
    input  do_line,
    output sclk,
    output host_do_o,
    output host_do_oe,
    output squelch_select_pin,
    output parallel_bw_select_0,
    output parallel_bw_select_1
  );
endinterface

// ### rxap_dev.sv
`timescale 1ns/1ps
module rxap_dev
  import rxap_pkg::*;
#(
  parameter int unsigned SLEEP_CYC      = SLEEP_BASE_CYC,
  parameter int unsigned WIN_CYC_PER_US = CLK_MHZ,
  parameter int unsigned SER_TMO        = SER_TMO_CYC
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  rxap_if.dev                   link,
  input  wire logic             demod_raw,
  output logic [CFG_W-1:0]      cfg_word,
  output logic [1:0]            slice_level_sel,
  output logic [1:0]            demod_bw_sel,
  output logic                  squelch_off,
  output rxap_ap_t              ap_state
);

  typedef enum logic [8:0] {
    SR_IDLE = 9'h001,
    SR_REL  = 9'h002,
    SR_ST1  = 9'h004,
    SR_ST2  = 9'h008,
    SR_ST3  = 9'h010,
    SR_LO   = 9'h020,
    SR_HI   = 9'h040,
    SR_STP1 = 9'h080,
    SR_STP2 = 9'h100
  } rxap_ser_t;

  logic [1:0]       sclk_q;
  logic [1:0]       dat_q;
  logic [1:0]       dem_q;
  logic [1:0]       sq_q;
  logic             sclk_d_r;
  logic             dat_d_r;
  logic             dem_d_r;
  rxap_ser_t        ser_r;
  rxap_ser_t        ser_nxt;
  logic [CFG_W-1:0] shift_r;
  logic [4:0]       nbits_r;
  logic [CFG_W-1:0] cfg_r;
  logic [12:0]      tmo_r;
  rxap_ap_t         ap_r;
  rxap_ap_t         ap_nxt;
  logic [31:0]      slp_r;
  logic [15:0]      wid_r;
  logic [4:0]       vcnt_r;
  logic [2:0]       bcnt_r;
  logic             do_o_r;
  logic             do_oe_r;
  logic             sqoff_r;

  // synchronisers: first stage read only by second stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 2'h0;
      dat_q  <= 2'h0;
      dem_q  <= 2'h0;
      sq_q   <= 2'h3;
    end else begin
      sclk_q <= {sclk_q[0], link.sclk};
      dat_q  <= {dat_q[0], link.do_line};
      dem_q  <= {dem_q[0], demod_raw};
      sq_q   <= {sq_q[0], link.squelch_select_pin};
    end
  end

  wire sclk_s    = sclk_q[1];
  wire dat_s     = dat_q[1];
  wire dem_s     = dem_q[1];
  wire sclk_rise = sclk_s & ~sclk_d_r;
  wire sclk_fall = ~sclk_s & sclk_d_r;
  wire dat_rise  = dat_s & ~dat_d_r;
  wire dat_fall  = ~dat_s & dat_d_r;
  wire dem_edge  = dem_s ^ dem_d_r;
  wire tmo_hit   = (ser_r != SR_IDLE) && (32'(tmo_r) >= SER_TMO - 1);

  // serial front end
  always_comb begin
    ser_nxt = ser_r;
    unique case (ser_r)
      SR_IDLE: if (sclk_s) ser_nxt = SR_REL;
      SR_REL:  if (sclk_fall) ser_nxt = dat_s ? SR_IDLE : SR_ST1;
      SR_ST1:  if (sclk_rise && !dat_s) ser_nxt = SR_ST2;
      SR_ST2: begin
        if (sclk_fall) ser_nxt = SR_IDLE;
        else if (dat_rise) ser_nxt = SR_ST3;
      end
      SR_ST3: begin
        if (sclk_fall) ser_nxt = SR_IDLE;
        else if (dat_fall) ser_nxt = SR_LO;
      end
      SR_LO:   if (sclk_rise) ser_nxt = SR_HI;
      SR_HI: begin
        // a data change that lands with the clock fall is the next bit, not a stop
        if (sclk_fall) ser_nxt = SR_LO;
        else if (dat_rise) ser_nxt = SR_STP1;
      end
      SR_STP1: begin
        if (sclk_fall) ser_nxt = SR_IDLE;
        else if (dat_fall) ser_nxt = SR_STP2;
      end
      SR_STP2: if (sclk_fall) ser_nxt = SR_IDLE;
      default: ser_nxt = SR_IDLE;
    endcase
    if (tmo_hit) ser_nxt = SR_IDLE;
  end

  wire              load = (ser_r == SR_STP2) && sclk_fall && !tmo_hit;
  wire [CFG_W-1:0]  lmask = (nbits_r >= 5'd20) ? {CFG_W{1'b1}} :
                            CFG_W'((32'h1 << nbits_r) - 32'h1);
  wire [CFG_W-1:0]  cfg_new = (cfg_r & ~lmask) | (shift_r & lmask);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_r    <= SR_IDLE;
      sclk_d_r <= 1'b0;
      dat_d_r  <= 1'b0;
      shift_r  <= '0;
      nbits_r  <= 5'h00;
      cfg_r    <= CFG_RESET;
      tmo_r    <= 13'h0000;
      do_oe_r  <= 1'b1;
    end else begin
      ser_r    <= ser_nxt;
      sclk_d_r <= sclk_s;
      dat_d_r  <= dat_s;
      do_oe_r  <= (ser_nxt == SR_IDLE);
      tmo_r    <= (sclk_rise || sclk_fall || ser_r == SR_IDLE) ? 13'h0000 : tmo_r + 13'h0001;
      if (ser_r == SR_ST3) begin
        nbits_r <= 5'h00;
      end else if (ser_r == SR_LO && sclk_rise) begin
        shift_r <= {shift_r[CFG_W-2:0], dat_s};
        if (nbits_r < 5'd20) nbits_r <= nbits_r + 5'h01;
      end
      if (load) cfg_r <= cfg_new;
    end
  end

  // auto-poll controller
  wire [4:0]  need    = rxap_valid_need(cfg_r[VCNT_LSB +: 2]);
  wire [31:0] slp_len = SLEEP_CYC << cfg_r[SLP_LSB +: 3];
  wire [31:0] win_cyc = WIN_US_TBL[{cfg_r[BW_LSB +: 2], cfg_r[WIN_LSB +: 3]}]
                        * WIN_CYC_PER_US;
  wire        pulse_ok = (32'(wid_r) > win_cyc);
  wire        pulse_bad = dem_edge && !pulse_ok;
  wire        pulse_good = dem_edge && pulse_ok;

  always_comb begin
    ap_nxt = ap_r;
    unique case (ap_r)
      RXAP_AWAKE: ap_nxt = RXAP_AWAKE;
      RXAP_SLEEP: if (slp_r >= slp_len - 32'h1) ap_nxt = RXAP_POLL;
      RXAP_POLL: begin
        if (need == 5'h00 || (pulse_good && vcnt_r + 5'h01 >= need))
          ap_nxt = RXAP_RECV;
        else if (pulse_bad && bcnt_r == 3'(BAD_LIMIT - 1))
          ap_nxt = RXAP_SLEEP;
      end
      RXAP_RECV:  ap_nxt = RXAP_RECV;
    endcase
    if (load) ap_nxt = cfg_new[BIT_AP_EN] ? RXAP_SLEEP : RXAP_AWAKE;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ap_r    <= RXAP_AWAKE;
      dem_d_r <= 1'b0;
      slp_r   <= 32'h0;
      wid_r   <= 16'h0000;
      vcnt_r  <= 5'h00;
      bcnt_r  <= 3'h0;
      do_o_r  <= 1'b0;
      sqoff_r <= 1'b1;
    end else begin
      ap_r    <= ap_nxt;
      dem_d_r <= dem_s;
      slp_r   <= (ap_r == RXAP_SLEEP && ap_nxt == RXAP_SLEEP) ? slp_r + 32'h1 : 32'h0;
      if (ap_r != RXAP_POLL || dem_edge) wid_r <= 16'h0000;
      else if (wid_r != 16'hffff) wid_r <= wid_r + 16'h0001;
      if (ap_r != RXAP_POLL) begin
        vcnt_r <= 5'h00;
        bcnt_r <= 3'h0;
      end else if (pulse_good) begin
        vcnt_r <= vcnt_r + 5'h01;
        bcnt_r <= 3'h0;
      end else if (pulse_bad) begin
        vcnt_r <= 5'h00;
        bcnt_r <= bcnt_r + 3'h1;
      end
      do_o_r  <= (ap_nxt == RXAP_AWAKE || ap_nxt == RXAP_RECV) ? dem_s : 1'b0;
      sqoff_r <= sq_q[1] ^ cfg_r[BIT_SQ];
    end
  end

  assign link.dev_do_o   = do_o_r;
  assign link.dev_do_oe  = do_oe_r;
  assign cfg_word        = cfg_r;
  assign slice_level_sel = cfg_r[SLICE_LSB +: 2];
  assign demod_bw_sel    = cfg_r[BW_LSB +: 2];
  assign squelch_off     = sqoff_r;
  assign ap_state        = ap_r;

endmodule

// ### rxap_host.sv
`timescale 1ns/1ps
module rxap_host
  import rxap_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  rxap_if.host             link,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata
);

  typedef enum logic [3:0] {
    HS_IDLE  = 4'h1,
    HS_START = 4'h2,
    HS_BITS  = 4'h4,
    HS_STOP  = 4'h8
  } rxap_hs_t;

  rxap_hs_t         st_r;
  logic [2:0]       idx_r;
  logic [4:0]       bit_r;
  logic [CFG_W-1:0] word_r;
  logic [4:0]       first_r;
  logic [7:0]       tmr_r;
  logic [2:0]       pins_r;
  logic [2:0]       pat_r;
  logic [31:0]      rdata_r;

  wire busy    = (st_r != HS_IDLE);
  wire step    = busy && (32'(tmr_r) >= HOST_HALF_CYC - 1);
  wire cur_bit = word_r[bit_r];
  wire cmd_wr  = wr && (addr == REG_CMD) && !busy;

  // {sclk, oe, data} for each step of the sequences
  function automatic logic [2:0] pattern(input rxap_hs_t s, input logic [2:0] i,
                                         input logic b);
    pattern = 3'b000;
    unique case (s)
      HS_IDLE:  pattern = 3'b000;
      HS_START: begin
        unique case (i)
          3'd0:    pattern = 3'b100;
          3'd1:    pattern = 3'b110;
          3'd2:    pattern = 3'b010;
          3'd3:    pattern = 3'b110;
          3'd4:    pattern = 3'b111;
          default: pattern = 3'b110;
        endcase
      end
      HS_BITS:  pattern = {i[0], 1'b1, b};
      HS_STOP: begin
        unique case (i)
          // clock stays high after the last bit so no extra bit is clocked in
          3'd0:    pattern = 3'b110;
          3'd1:    pattern = 3'b110;
          3'd2:    pattern = 3'b111;
          3'd3:    pattern = 3'b110;
          default: pattern = 3'b000;
        endcase
      end
    endcase
  endfunction

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= HS_IDLE;
      idx_r   <= 3'h0;
      bit_r   <= 5'h00;
      word_r  <= '0;
      first_r <= 5'h00;
      tmr_r   <= 8'h00;
      pins_r  <= PINS_RESET;
      pat_r   <= 3'b000;
    end else begin
      pat_r <= pattern(st_r, idx_r, cur_bit);
      tmr_r <= (!busy || step) ? 8'h00 : tmr_r + 8'h01;
      if (wr && addr == REG_PINS) pins_r <= wdata[2:0];
      if (cmd_wr) begin
        word_r  <= wdata[CFG_W-1:0];
        first_r <= (wdata[CMD_FIRST_LSB +: 5] > 5'd19) ? 5'd19 : wdata[CMD_FIRST_LSB +: 5];
        bit_r   <= (wdata[CMD_FIRST_LSB +: 5] > 5'd19) ? 5'd19 : wdata[CMD_FIRST_LSB +: 5];
        st_r    <= HS_START;
        idx_r   <= 3'h0;
      end else if (step) begin
        unique case (st_r)
          HS_START: begin
            idx_r <= (idx_r == 3'd5) ? 3'h0 : idx_r + 3'h1;
            if (idx_r == 3'd5) st_r <= HS_BITS;
          end
          HS_BITS: begin
            idx_r <= {2'b00, ~idx_r[0]};
            if (idx_r[0]) begin
              if (bit_r == 5'h00) begin
                st_r  <= HS_STOP;
                idx_r <= 3'h0;
              end else begin
                bit_r <= bit_r - 5'h01;
              end
            end
          end
          HS_STOP: begin
            idx_r <= idx_r + 3'h1;
            if (idx_r == 3'd4) begin
              st_r  <= HS_IDLE;
              idx_r <= 3'h0;
            end
          end
          default: st_r <= HS_IDLE;
        endcase
      end
    end
  end

  wire [31:0] rd_mux = (addr == REG_CMD)    ? {7'h00, first_r, word_r} :
                       (addr == REG_STATUS) ? {31'h0, busy} :
                       (addr == REG_PINS)   ? {29'h0, pins_r} : 32'h0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rdata_r <= 32'h0;
    else        rdata_r <= rd ? rd_mux : 32'h0;
  end

  assign link.sclk                 = pat_r[2];
  assign link.host_do_oe           = pat_r[1];
  assign link.host_do_o            = pat_r[0];
  assign link.squelch_select_pin   = pins_r[0];
  assign link.parallel_bw_select_0 = pins_r[1];
  assign link.parallel_bw_select_1 = pins_r[2];
  assign rdata                     = rdata_r;

endmodule

// ### rxap_checker.sv
`timescale 1ns/1ps
module rxap_checker
  import rxap_pkg::*;
#(
  parameter int unsigned SLEEP_CYC = 200
) (
  input wire logic             sys_clk,
  input wire logic             rst_n,
  input wire logic             sclk,
  input wire logic             dev_do_o,
  input wire logic             dev_do_oe,
  input wire logic             host_do_o,
  input wire logic             host_do_oe,
  input wire logic             squelch_select_pin,
  input wire logic [CFG_W-1:0] cfg_word,
  input wire logic             squelch_off,
  input wire rxap_ap_t         ap_state
);
  logic [15:0] low_r;
  logic [31:0] slp_r;
  wire         in_slp = ap_state == RXAP_SLEEP;
  wire  [31:0] slp_need = SLEEP_CYC << cfg_word[14:12];

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // low_r: cycles since the serial clock was last high
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_r <= 16'h0;
      slp_r <= 32'h0;
    end else begin
      low_r <= sclk ? 16'h0 : low_r + {15'h0, ~&low_r};
      slp_r <= in_slp ? slp_r + 32'h1 : 32'h0;
    end
  end

  no_contention_a: assert property (!(dev_do_oe && host_do_oe))
    else $error("both ends drive the data line");
  release_time_a: assert property ($rose(sclk) |-> ##[1:5] !dev_do_oe)
    else $error("data pin not released after clock rise");
  stop_redrive_a: assert property ($fell(host_do_oe) |-> ##[1:8] dev_do_oe)
    else $error("data pin not driven again after stop");
  data_setup_a: assert property ($rose(sclk) && host_do_oe |-> $stable(host_do_o))
    else $error("data changed at clock rise");
  cfg_update_a: assert property ($changed(cfg_word) |-> low_r < 16'd12)
    else $error("config changed outside a stop");
  squelch_track_a: assert property (
    ($stable(squelch_select_pin) && $stable(cfg_word)) [*4]
    |-> squelch_off == (squelch_select_pin ^ cfg_word[BIT_SQ]))
    else $error("squelch disable mismatch");
  poll_low_a: assert property (
    $stable(ap_state) && ap_state inside {RXAP_SLEEP, RXAP_POLL} && dev_do_oe |-> !dev_do_o)
    else $error("data output not held low while polling");
  recv_sticky_a: assert property (
    ap_state == RXAP_RECV && low_r > 16'd40 |=> ap_state == RXAP_RECV)
    else $error("left continuous receive on its own");
  sleep_length_a: assert property (ap_state == RXAP_POLL && $past(in_slp)
    |-> slp_r + 32'h1 >= slp_need && slp_r <= slp_need + 32'h1)
    else $error("sleep duration wrong");
  host_clock_rate_a: assert property (host_do_oe |-> 32'(low_r) < SER_TMO_CYC)
    else $error("serial clock stopped while host drives the line");

  cover property (ap_state == RXAP_SLEEP ##1 ap_state == RXAP_POLL);
  cover property (ap_state == RXAP_POLL ##1 ap_state == RXAP_SLEEP);
  cover property (ap_state == RXAP_POLL ##1 ap_state == RXAP_RECV);
endmodule

// ### rx_autopoll_serial_config_tb_top.sv
`timescale 1ns/1ps
module rx_autopoll_serial_config_tb_top
  import rxap_pkg::*;
;
  localparam logic [19:0] cfg_full = 20'h43d2a;
  localparam logic [19:0] cfg_ap4  = 20'h48ef8;
  localparam logic [19:0] cfg_ap0  = 20'h49e78;
  logic             sys_clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             demod_raw = 1'b0;
  logic [3:0]       addr = 4'h0;
  logic [31:0]      wdata = 32'h0;
  logic             wr = 1'b0;
  logic             rd = 1'b0;
  logic [31:0]      rdata;
  logic [CFG_W-1:0] cfg_word;
  logic [1:0]       slice_level_sel;
  logic [1:0]       demod_bw_sel;
  logic             squelch_off;
  rxap_ap_t         ap_state;
  logic             sclk_q = 1'b0;
  logic [21:0]      cap = 22'h0;
  int               bad_count = 0;
  int               comparisons = 0;

  rxap_if link ();
  always #20 sys_clk = ~sys_clk;

  rxap_dev #(.SLEEP_CYC(200), .WIN_CYC_PER_US(1), .SER_TMO(400)) u_rxap_dev (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(link.dev), .demod_raw(demod_raw),
    .cfg_word(cfg_word), .slice_level_sel(slice_level_sel),
    .demod_bw_sel(demod_bw_sel), .squelch_off(squelch_off), .ap_state(ap_state));
  rxap_host u_rxap_host (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(link.host), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  rxap_checker #(.SLEEP_CYC(200)) u_rxap_checker (
    .sys_clk(sys_clk), .rst_n(rst_n), .sclk(link.sclk), .dev_do_o(link.dev_do_o),
    .dev_do_oe(link.dev_do_oe), .host_do_o(link.host_do_o),
    .host_do_oe(link.host_do_oe), .squelch_select_pin(link.squelch_select_pin),
    .cfg_word(cfg_word), .squelch_off(squelch_off), .ap_state(ap_state));

  // bits seen on the wire at each clock rise while the host owns the line
  always @(posedge sys_clk) begin
    sclk_q <= link.sclk;
    if (link.sclk && !sclk_q && !link.dev_do_oe) cap <= {cap[20:0], link.do_line};
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timeout(input string what);
    bad_count++;
    $display("[FAIL] %s expected done seen timeout", what);
    print_verdict();
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic look();
    step(5);
    @(negedge sys_clk);
  endtask

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic load(input logic [4:0] first, input logic [19:0] w);
    logic [31:0] s;
    int i;
    wreg(REG_CMD, {7'h0, first, w});
    s = 32'h1;
    for (i = 0; i < 4000 && s[0] !== 1'b0; i++) rreg(REG_STATUS, s);
    if (s[0] !== 1'b0) timeout("load");
    step(8);
    @(negedge sys_clk);
  endtask

  task automatic wait_st(input rxap_ap_t s);
    int i;
    for (i = 0; i < 2000 && ap_state !== s; i++) @(negedge sys_clk);
    if (ap_state !== s) timeout("state wait");
  endtask

  task automatic pulses(input int n, input int w);
    repeat (n) begin
      step(w);
      demod_raw <= ~demod_raw;
    end
  endtask

  initial begin
    logic [31:0] r;
    logic [19:0] exp;
    int i;
    step(6);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk("cfg reset", CFG_RESET, cfg_word);
    chk("state reset", RXAP_AWAKE, ap_state);
    chk("slice reset", 2'h3, slice_level_sel);
    chk("bw reset", 2'h3, demod_bw_sel);
    chk("squelch reset", 1'b1, squelch_off);
    rreg(REG_PINS, r);
    chk("pins reg", PINS_RESET, r);
    rreg(4'hc, r);
    chk("unmapped read", 32'h0, r);
    $display("test reset done");

    load(5'd19, cfg_full);
    chk("cfg full", cfg_full, cfg_word);
    chk("wire bits", {1'b0, cfg_full}, cap[20:0]);
    chk("line driven", 1'b1, link.dev_do_oe);
    @(posedge sys_clk) demod_raw <= 1'b1;
    look();
    chk("awake follows", 1'b1, link.dev_do_o);
    $display("test full load done");

    for (i = 0; i < 4; i++) begin
      exp = {cfg_full[19:7], i[1:0], i[1:0], 3'h0};
      load(5'd6, {~cfg_full[19:7], exp[6:0]});
      chk("cfg partial", exp, cfg_word);
      chk("slice code", i, slice_level_sel);
      chk("bw code", i, demod_bw_sel);
    end
    $display("test partial loads done");

    wreg(REG_PINS, 32'h6);
    look();
    chk("squelch pin low", 1'b0, squelch_off);
    wreg(REG_PINS, {29'h0, PINS_RESET});
    look();
    chk("squelch pin high", 1'b1, squelch_off);
    $display("test squelch done");

    load(5'd19, cfg_ap4);
    chk("enter sleep", RXAP_SLEEP, ap_state);
    chk("held low", 1'b0, link.dev_do_o);
    wait_st(RXAP_POLL);
    pulses(3, 10);
    look();
    chk("three bad", RXAP_POLL, ap_state);
    pulses(1, 10);
    look();
    chk("four bad", RXAP_SLEEP, ap_state);
    wait_st(RXAP_POLL);
    pulses(3, 60);
    look();
    chk("three valid", RXAP_POLL, ap_state);
    pulses(1, 60);
    look();
    chk("four valid", RXAP_RECV, ap_state);
    step(1200);
    @(negedge sys_clk);
    chk("stays receiving", RXAP_RECV, ap_state);
    chk("recv follows", demod_raw, link.dev_do_o);
    $display("test auto-poll done");

    load(5'd19, cfg_ap0);
    chk("reload sleep", RXAP_SLEEP, ap_state);
    wait_st(RXAP_RECV);
    chk("zero valid", RXAP_RECV, ap_state);
    load(5'd19, CFG_RESET);
    chk("poll off", RXAP_AWAKE, ap_state);
    $display("test reload done");
    print_verdict();
  end
endmodule
